//--- common/spi_host_cfg.svh
// constants for the serial flash host controller
// included by the host module, the flash model and the bench; definitions only
`ifndef SPI_HOST_CFG_SVH
`define SPI_HOST_CFG_SVH
// register byte offsets
`define REG_CTRL 12'h000
`define REG_CMD 12'h004
`define REG_ADDR 12'h008
`define REG_TXDATA 12'h00C
`define REG_COUNT 12'h010
`define REG_STATUS 12'h014
`define REG_RXDATA 12'h018
`define REG_DIV 12'h01C
// field positions
`define CTRL_START 0
`define STAT_BUSY 0
`define STAT_DONE 1
`define STAT_WIP 2
`define STAT_WEL 3
// reset values
`define DIV_RESET 8'h04
// opcodes
`define OP_WREN 8'h06
`define OP_WRITE_DISABLE_CMD 8'h04
`define OP_RDID 8'h9F
`define OP_RDSTAT 8'h05
`define OP_WRSTAT 8'h01
`define OP_LKWR 8'hE5
`define OP_LKRD 8'hE8
`define OP_READ 8'h03
`define OP_FREAD 8'h0B
`define OP_PGWR 8'h0A
`define OP_PGPRG 8'h02
`define OP_PGERS 8'hDB
`define OP_SSERS 8'h20
`define OP_SERS 8'hD8
`define OP_BERS 8'hC7
`define OP_DPD 8'hB9
`define OP_RDPD 8'hAB
// array geometry
`define ADDR_TOP 24'h07FFFF
`define PAGE_BYTES 9'h100
`define ID_BYTES_MAX 9'h014
// status register bit positions inside the device, and the top bit index of a byte
`define DEV_WIP_BIT 0
`define DEV_WEL_BIT 1
`define BYTE_BITS 3'h7
`endif

//--- common/spi_host_pkg.sv
// types for the serial flash host controller
// constants come from spi_host_cfg.svh
package spi_host_pkg;
	// shape of one command in terms of its phases
	typedef struct packed {
		logic has_addr;
		logic has_dummy;
		logic data_in;
		logic data_out;
		logic needs_wel;
		logic valid;
	} cmd_shape_t;
	// link pins driven by the host
	typedef struct packed {
		logic sel_n;
		logic sclk;
		logic mosi;
	} link_out_t;
	typedef enum logic [2:0] {
		ST_IDLE, ST_SEL, ST_LOW, ST_HIGH, ST_END, ST_GAP
	} host_state_t;
endpackage

//--- hw/spi_flash_host.sv
// spi host that drives a 4Mbit serial flash over select, clock and data pins
// assumes an apb master for software, and the device sampling on rising sclk
//
// Functional notes
// - all bytes shift most significant bit first
// - first rising edge after select samples opcode
// - opcode then address, dummy, data per table
// - reads end by raising select anytime
// - modifying commands deselect on byte boundary
// - latch set is opcode only, then deselect
// - latch must be set before modifying commands
// - 03h three address; 0Bh adds dummy byte
// - 0Ah and 02h carry 1 to 256 bytes
// - E5h and E8h: address plus one byte
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "spi_host_cfg.svh"

module spi_flash_host
	import spi_host_pkg::*;
#(
	parameter int DIV_W = 8
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// flash link
	output logic flash_sel_n,
	output logic flash_sclk,
	output logic serial_in_pin,
	input wire logic flash_miso
);
	initial begin
		if (DIV_W < 2 || DIV_W > 8) $error("DIV_W must be 2..8");
	end

	// decode the phases of one opcode
	function automatic cmd_shape_t shape_of(input logic [7:0] op);
		cmd_shape_t s;
		s = '0;
		s.valid = 1'b1;
		case (op)
			`OP_WREN, `OP_WRITE_DISABLE_CMD, `OP_RDPD, `OP_DPD: ; // opcode only
			`OP_BERS: s.needs_wel = 1'b1; // software sends 06h first
			`OP_RDID, `OP_RDSTAT: s.data_in = 1'b1;
			`OP_WRSTAT: begin
				s.data_out = 1'b1;
				s.needs_wel = 1'b1;
			end
			`OP_READ, `OP_LKRD: begin
				s.has_addr = 1'b1;
				s.data_in = 1'b1;
			end
			`OP_FREAD: begin
				s.has_addr = 1'b1;
				s.has_dummy = 1'b1;
				s.data_in = 1'b1;
			end
			`OP_LKWR, `OP_PGWR, `OP_PGPRG: begin
				s.has_addr = 1'b1;
				s.data_out = 1'b1;
				s.needs_wel = 1'b1;
			end
			`OP_PGERS, `OP_SSERS, `OP_SERS: begin
				s.has_addr = 1'b1;
				s.needs_wel = 1'b1;
			end
			default: s.valid = 1'b0;
		endcase
		return s;
	endfunction

	// software registers
	logic [7:0] cmd;
	logic [23:0] addr;
	logic [31:0] txdata;
	logic [8:0] count;
	logic [DIV_W-1:0] div;
	logic [31:0] rxdata;
	logic busy;
	logic done;
	logic bad_cmd;
	logic start_req;
	logic [7:0] last_status;
	// engine
	host_state_t state;
	logic [DIV_W-1:0] tick;
	logic [7:0] shreg;
	logic [2:0] bitn;
	logic [8:0] bytes_left;
	logic [1:0] phase; // 0 opcode 1 address 2 dummy 3 data
	logic [1:0] abyte;
	logic [1:0] dbyte;
	logic [2:0] miso_sync;
	cmd_shape_t shp;
	link_out_t lnk;

	assign shp = shape_of(cmd);

	wire apb_wr = psel && penable && pwrite && pready;
	wire apb_rd = psel && !penable && !pwrite;
	wire at_div = (tick == div);
	wire byte_end = (bitn == `BYTE_BITS);
	wire miso_bit = miso_sync[2];

	// apb answers every access one cycle after setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && (paddr > `REG_DIV || paddr[1:0] != 2'h0);
		end
	end

	// register writes; start is ignored while a frame runs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd <= 8'h00;
			addr <= 24'h000000;
			txdata <= 32'h00000000;
			count <= 9'h001;
			div <= DIV_W'(`DIV_RESET);
			start_req <= 1'b0;
		end else if (clk_en) begin
			start_req <= 1'b0;
			if (apb_wr) begin
				case (paddr)
					`REG_CTRL: start_req <= pwdata[`CTRL_START] && !busy;
					`REG_CMD: cmd <= pwdata[7:0];
					`REG_ADDR: addr <= pwdata[23:0] & `ADDR_TOP; // wrap into array
					`REG_TXDATA: txdata <= pwdata;
					`REG_COUNT: count <= pwdata[8:0];
					`REG_DIV: div <= (pwdata[DIV_W-1:0] == '0) ? DIV_W'(1) : pwdata[DIV_W-1:0];
					default: ;
				endcase
			end
		end
	end

	// read mux, taken at the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (clk_en && apb_rd) begin
			case (paddr)
				`REG_CMD: prdata <= {24'h000000, cmd};
				`REG_ADDR: prdata <= {8'h00, addr};
				`REG_TXDATA: prdata <= txdata;
				`REG_COUNT: prdata <= {23'h000000, count};
				`REG_STATUS: prdata <= {27'h0, bad_cmd, last_status[`DEV_WEL_BIT],
					last_status[`DEV_WIP_BIT], done, busy};
				`REG_RXDATA: prdata <= rxdata;
				`REG_DIV: prdata <= {{(32-DIV_W){1'b0}}, div};
				default: prdata <= 32'h00000000;
			endcase
		end
	end

	// three-stage sampling of the returning data pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			miso_sync <= 3'h0;
		end else if (clk_en) begin
			miso_sync <= {miso_sync[1:0], flash_miso};
		end
	end

	// frame engine: sclk idles low, data changes on falling edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
			lnk <= '{sel_n: 1'b1, sclk: 1'b0, mosi: 1'b0};
			tick <= '0;
			shreg <= 8'h00;
			bitn <= 3'h0;
			bytes_left <= 9'h000;
			phase <= 2'h0;
			abyte <= 2'h0;
			dbyte <= 2'h0;
			busy <= 1'b0;
			done <= 1'b0;
			bad_cmd <= 1'b0;
			rxdata <= 32'h00000000;
			last_status <= 8'h00;
		end else if (clk_en) begin
			if (apb_wr && paddr == `REG_CTRL && pwdata[`CTRL_START])
				done <= 1'b0;
			tick <= at_div ? '0 : tick + 1'b1;
			case (state)
				ST_IDLE: begin
					tick <= '0;
					if (start_req) begin
						if (!shp.valid) begin
							bad_cmd <= 1'b1;
							done <= 1'b1;
						end else begin
							bad_cmd <= 1'b0;
							busy <= 1'b1;
							lnk.sel_n <= 1'b0;
							shreg <= cmd; // opcode first
							lnk.mosi <= cmd[7];
							bitn <= 3'h0;
							phase <= 2'h0;
							abyte <= 2'h2;
							dbyte <= 2'h3;
							bytes_left <= (count == 9'h000) ? 9'h001 :
								((shp.data_out || shp.data_in) && count > `PAGE_BYTES) ?
								`PAGE_BYTES : count;
							rxdata <= 32'h00000000;
							state <= ST_SEL;
						end
					end
				end
				ST_SEL: if (at_div) state <= ST_LOW;
				ST_LOW: if (at_div) begin
					lnk.sclk <= 1'b1; // device samples here
					shreg <= {shreg[6:0], miso_bit};
					state <= ST_HIGH;
				end
				ST_HIGH: if (at_div) begin
					lnk.sclk <= 1'b0;
					bitn <= bitn + 3'h1;
					state <= ST_LOW;
					if (byte_end) begin
						// whole bytes only, so select rises on a byte boundary
						if (phase == 2'h3 && shp.data_in) begin
							rxdata <= {rxdata[23:0], shreg};
							if (cmd == `OP_RDSTAT) last_status <= shreg;
						end
						if (phase == 2'h0 && shp.has_addr) begin
							phase <= 2'h1;
							shreg <= addr[23:16];
							lnk.mosi <= addr[23];
						end else if (phase == 2'h1 && abyte != 2'h0) begin
							abyte <= abyte - 2'h1;
							shreg <= (abyte == 2'h2) ? addr[15:8] : addr[7:0];
							lnk.mosi <= (abyte == 2'h2) ? addr[15] : addr[7];
						end else if (phase != 2'h3 && shp.has_dummy && phase != 2'h2) begin
							phase <= 2'h2;
							shreg <= 8'h00;
							lnk.mosi <= 1'b0;
						end else if (phase != 2'h3 && (shp.data_in || shp.data_out)) begin
							phase <= 2'h3;
							shreg <= txdata[31:24];
							lnk.mosi <= shp.data_out ? txdata[31] : 1'b0;
							dbyte <= 2'h2;
						end else if (phase == 2'h3 && bytes_left > 9'h001) begin
							bytes_left <= bytes_left - 9'h001;
							shreg <= txdata[8*dbyte +: 8];
							lnk.mosi <= shp.data_out ? txdata[8*dbyte+7] : 1'b0;
							dbyte <= dbyte - 2'h1;
						end else begin
							state <= ST_END; // reads end after the asked bytes
						end
					end else begin
						lnk.mosi <= shp.data_out || phase != 2'h3 ? shreg[7] : 1'b0;
					end
				end
				ST_END: if (at_div) begin
					lnk.sel_n <= 1'b1; // device acts on the command here
					state <= ST_GAP;
				end
				ST_GAP: if (at_div) begin
					busy <= 1'b0;
					done <= 1'b1;
					state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	assign flash_sel_n = lnk.sel_n;
	assign flash_sclk = lnk.sclk;
	assign serial_in_pin = lnk.mosi;

	// count clock pulses per frame for the byte boundary check
	logic [11:0] pulses;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulses <= 12'h000;
		end else if (clk_en) begin
			if (lnk.sel_n)
				pulses <= 12'h000;
			else if (state == ST_LOW && at_div)
				pulses <= pulses + 12'h001;
		end
	end

	a_byte_boundary: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(flash_sel_n) |-> pulses[2:0] == 3'h0)
		else $error("select rose off a byte boundary");
	a_sclk_low_sel: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(flash_sel_n) |-> !flash_sclk)
		else $error("sclk high when select fell");
	a_sel_sclk_idle: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(flash_sel_n) |-> !flash_sclk ##1 !flash_sclk)
		else $error("sclk active at deselect");
	a_wren_len: assert property (@(posedge pclk) disable iff (!presetn)
		($rose(flash_sel_n) && cmd == `OP_WREN) |-> pulses == 12'h008)
		else $error("latch set frame not eight pulses");
	a_read_len: assert property (@(posedge pclk) disable iff (!presetn)
		($rose(flash_sel_n) && cmd == `OP_FREAD) |-> pulses >= 12'h028)
		else $error("fast read frame too short");
	a_erase_len: assert property (@(posedge pclk) disable iff (!presetn)
		($rose(flash_sel_n) && cmd == `OP_SERS) |-> pulses == 12'h020)
		else $error("sector erase frame not 32 pulses");
	a_bulk_len: assert property (@(posedge pclk) disable iff (!presetn)
		($rose(flash_sel_n) && cmd == `OP_BERS) |-> pulses == 12'h008)
		else $error("bulk erase frame not eight pulses");
	a_busy_done: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(busy) |-> done && flash_sel_n)
		else $error("busy fell without done");
	a_addr_range: assert property (@(posedge pclk) disable iff (!presetn)
		(addr & ~`ADDR_TOP) == 24'h000000)
		else $error("address beyond array");
endmodule

//--- tb/flash_dev_model.sv
// behavioural serial flash: opcode framing, write latch, busy timer, array
// assumes the host shifts on sclk with select active low and sclk idling low
`timescale 1ns/10ps
`include "spi_host_cfg.svh"
module flash_dev_model (
	// link pins
	input wire logic sel_n,
	input wire logic sclk,
	input wire logic mosi,
	output logic miso
);
	logic [7:0] mem [0:524287]; // 2048 pages of 256 bytes
	logic [7:0] op;
	logic [7:0] sh;
	logic [7:0] ob;
	logic [23:0] adr;
	logic [7:0] inq [$];
	logic [7:0] lock [0:7]; // bit0 write-locks one 64KB sector
	logic latch;
	logic busy;
	logic dpd;
	int nb;
	// power-up: array erased, latch and busy clear
	initial begin
		for (int i = 0; i < 524288; i++) mem[i] = 8'hFF;
		for (int i = 0; i < 8; i++) lock[i] = 8'h00;
		latch = 0;
		busy = 0;
		dpd = 0;
		miso = 0;
		nb = 0;
	end
	// header length in bytes before data out
	function automatic int hdr(input logic [7:0] o);
		case (o)
			`OP_READ, `OP_LKRD: return 4;
			`OP_FREAD: return 5;
			default: return 1;
		endcase
	endfunction
	// select fall starts a fresh transaction
	always @(negedge sel_n) begin
		nb = 0;
		inq.delete();
	end
	// bits latched on rising sclk, msb first, first byte is the opcode
	always @(posedge sclk) if (!sel_n) begin
		sh = {sh[6:0], mosi};
		nb++;
		if (nb == 8) op = sh;
		else if (nb % 8 == 0 && nb <= 32) adr = {adr[15:0], sh} & `ADDR_TOP;
		else if (nb % 8 == 0) inq.push_back(sh);
	end
	// data out on falling sclk; array reads give garbage while busy
	always @(negedge sclk) if (!sel_n && nb >= 8 * hdr(op)
			&& (op == `OP_READ || op == `OP_FREAD || op == `OP_RDSTAT
			|| op == `OP_LKRD)) begin
		if (nb % 8 == 0) begin
			ob = (op == `OP_RDSTAT) ? {6'h00, latch, busy} :
				(op == `OP_LKRD) ? lock[adr[18:16]] : mem[adr[18:0]];
			if (op == `OP_READ || op == `OP_FREAD) adr = (adr + 1) & `ADDR_TOP;
		end
		miso = (busy && (op == `OP_READ || op == `OP_FREAD)) ? ~miso : ob[7 - nb % 8];
	end
	// deselect inverts the data line; commands act only on whole bytes
	always @(posedge sel_n) begin
		miso = ~miso;
		if (nb % 8 == 0 && nb > 0) case (op)
			`OP_WREN: latch = 1;
			`OP_WRITE_DISABLE_CMD: latch = 0;
			`OP_DPD: dpd = 1;
			`OP_RDPD: dpd = 0;
			`OP_LKWR: if (latch && !busy && !dpd && inq.size() == 1) begin
				lock[adr[18:16]] = inq[0];
				latch = 0;
			end
			`OP_SERS: if (latch && !busy && !dpd && !lock[adr[18:16]][0]) begin
				for (int i = 0; i < 65536; i++) mem[{adr[18:16], 16'h0000} + i] = 8'hFF;
				latch = 0;
				busy = 1;
			end
			`OP_PGPRG: if (latch && !busy && !dpd && inq.size() > 0
					&& !lock[adr[18:16]][0]) begin
				foreach (inq[i]) mem[{adr[18:8], adr[7:0] + 8'(i)}] &= inq[i];
				latch = 0;
				busy = 1;
			end
			`OP_SSERS: if (latch && !busy && !dpd && !lock[adr[18:16]][0]) begin
				for (int i = 0; i < 4096; i++) mem[{adr[18:12], 12'h000} + i] = 8'hFF;
				latch = 0;
				busy = 1;
			end
			default: ;
		endcase
	end
	// internal cycle time, kept short so polling stays cheap
	always @(posedge busy) begin
		#3000;
		busy = 0;
	end
endmodule

//--- tb/serial_flash_command_decoder_bench.sv
// self-checking bench: apb tasks drive the host, a flash model answers
// assumes the host register map and the model's short busy time
`timescale 1ns/10ps
`include "spi_host_cfg.svh"
module serial_flash_command_decoder_bench import spi_host_pkg::*; ;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic [31:0] rq;
	logic pready, pslverr, re, sel_n, sclk, mosi, miso;
	logic [7:0] ops [10] = '{`OP_WRITE_DISABLE_CMD, `OP_RDID, `OP_WRSTAT, `OP_LKWR, `OP_LKRD,
		`OP_PGERS, `OP_SERS, `OP_BERS, `OP_DPD, `OP_RDPD};
	int err_count = 0;
	int n_compared = 0;
	int cycles = 0;
	// 100 MHz clock
	always #5 pclk = ~pclk;
	spi_flash_host #(.DIV_W(8)) uut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_sel_n(sel_n),
		.flash_sclk(sclk), .serial_in_pin(mosi), .flash_miso(miso));
	flash_dev_model dev (.sel_n(sel_n), .sclk(sclk), .mosi(mosi), .miso(miso));
	task automatic report_and_stop;
		if (err_count == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one apb transfer; request held until the rising edge that sees pready high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rq = prdata;
		re = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// load a command, start it and poll until done
	task automatic run(input logic [7:0] op, input logic [23:0] a, input logic [31:0] n,
		input logic [31:0] tx);
		apb(1, `REG_CMD, {24'h000000, op});
		apb(1, `REG_ADDR, {8'h00, a});
		apb(1, `REG_COUNT, n);
		apb(1, `REG_TXDATA, tx);
		apb(1, `REG_CTRL, 32'h00000001);
		do apb(0, `REG_STATUS, 32'h00000000); while (rq[`STAT_DONE] !== 1'b1);
	endtask
	task automatic dev_status;
		run(`OP_RDSTAT, 24'h000000, 32'h00000001, 32'h00000000);
		apb(0, `REG_RXDATA, 32'h00000000);
	endtask
	task automatic wait_idle;
		do dev_status(); while (rq[0] !== 1'b0);
	endtask
	task automatic read4(input logic [7:0] op, input logic [31:0] exp);
		run(op, 24'h000100, 32'h00000004, 32'h00000000);
		apb(0, `REG_RXDATA, 32'h00000000);
		chk("read data", exp, rq);
	endtask
	// hang guard
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 60000) begin
			err_count++;
			report_and_stop();
		end
	end
	// main sequence
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1;
		apb(0, `REG_COUNT, 32'h0);
		chk("count reset", 32'h1, rq);
		apb(0, `REG_DIV, 32'h0);
		chk("div reset", {24'h0, `DIV_RESET}, rq);
		apb(0, 12'h020, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, re});
		run(`OP_WREN, 24'h0, 32'h1, 32'h0);
		dev_status();
		chk("latch set", 32'h02, {24'h0, rq[7:0]});
		run(`OP_PGPRG, 24'h000100, 32'h4, 32'h12345678);
		dev_status();
		chk("busy, latch cleared", 32'h01, {24'h0, rq[7:0]});
		wait_idle();
		read4(`OP_READ, 32'h12345678);
		read4(`OP_FREAD, 32'h12345678);
		run(`OP_PGPRG, 24'h000100, 32'h4, 32'h0);
		read4(`OP_READ, 32'h12345678);
		run(`OP_WREN, 24'h0, 32'h1, 32'h0);
		run(`OP_SSERS, 24'h000123, 32'h1, 32'h0);
		wait_idle();
		read4(`OP_READ, 32'hFFFFFFFF);
		run(`OP_WREN, 24'h0, 32'h1, 32'h0);
		run(`OP_DPD, 24'h0, 32'h1, 32'h0);
		run(`OP_PGPRG, 24'h000100, 32'h4, 32'h0);
		run(`OP_RDPD, 24'h0, 32'h1, 32'h0);
		read4(`OP_READ, 32'hFFFFFFFF);
		run(`OP_WREN, 24'h0, 32'h1, 32'h0);
		run(`OP_LKWR, 24'h000000, 32'h1, 32'h01000000);
		run(`OP_LKRD, 24'h000000, 32'h1, 32'h0);
		apb(0, `REG_RXDATA, 32'h00000000);
		chk("lock read", 32'h01, {24'h0, rq[7:0]});
		run(`OP_WREN, 24'h0, 32'h1, 32'h0);
		run(`OP_PGPRG, 24'h000100, 32'h4, 32'h0);
		read4(`OP_READ, 32'hFFFFFFFF);
		run(8'h77, 24'h0, 32'h1, 32'h0);
		chk("bad opcode status", 32'h3, {30'h0, rq[4], rq[1]});
		for (int i = 0; i < 10; i++) begin
			run(ops[i], 24'h0, 32'h1, 32'hA5000000);
			chk("opcode accepted", 32'h0, {31'h0, rq[4]});
			chk("opcode seen", {24'h0, ops[i]}, {24'h0, dev.op});
		end
		report_and_stop();
	end
endmodule
